// >>> shared/bit_unit_pkg.sv
// Behaviour
// - Bit compare: Z set when bits equal
// - Bit compare writes nothing; S cleared
// - Bit complement inverts one bit; two bytes, four cycles
// - Bit complement: Z from result, S cleared
// - Bit clear forces bit to zero, flags kept
// - Bit set forces bit to one, flags kept
// - Second byte: register, bit position, variant
// - Bit OR into working bit zero, six cycles
// - Bit OR working bit zero into register bit
// - Bit OR: Z from result bit, S cleared
package bit_unit_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int BUS_AW = 12;
  localparam int BUS_DW = 32;

  // Opcodes of the bit instructions handled here
  localparam logic [7:0] OPC_BIT_COMPARE    = 8'h17;
  localparam logic [7:0] OPC_BIT_COMPLEMENT = 8'h57;
  localparam logic [7:0] OPC_BIT_CLEAR_SET  = 8'h77;
  localparam logic [7:0] OPC_BIT_OR_MERGE   = 8'h07;

  // Instruction length and execution time
  localparam logic [1:0] BYTES_SHORT  = 2'h2;
  localparam logic [1:0] BYTES_LONG   = 2'h3;
  localparam logic [2:0] CYCLES_SHORT = 3'h4;
  localparam logic [2:0] CYCLES_LONG  = 3'h6;

  // Execution steps, counted from the first busy cycle
  localparam logic [2:0] STEP_READ_WORK = 3'h0;
  localparam logic [2:0] STEP_READ_FULL = 3'h1;
  localparam logic [2:0] STEP_OP_SHORT  = 3'h2;
  localparam logic [2:0] STEP_OP_LONG   = 3'h3;

  // Register map, byte addresses
  localparam logic [11:0] OFF_CTRL    = 12'h000;
  localparam logic [11:0] OFF_INSTR   = 12'h004;
  localparam logic [11:0] OFF_FLAGS   = 12'h008;
  localparam logic [11:0] OFF_STATUS  = 12'h00c;
  localparam logic [11:0] OFF_PAGE    = 12'h010;
  localparam logic [11:0] OFF_RF_BASE = 12'h400;

  // Field positions
  localparam int CTRL_START_BIT   = 0;
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_ILLEGAL_BIT = 1;
  localparam int STAT_LEN_LSB     = 2;
  localparam int B2_VARIANT_BIT   = 0;
  localparam int B2_BIT_LSB       = 1;
  localparam int B2_REG_LSB       = 4;
  localparam int FLAG_C           = 7;
  localparam int FLAG_Z           = 6;
  localparam int FLAG_S           = 5;
  localparam int FLAG_V           = 4;
  localparam int FLAG_D           = 3;
  localparam int FLAG_H           = 2;

  // Reset values
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [3:0]  PAGE_RST  = 4'h0;
  localparam logic [23:0] INSTR_RST = 24'h000000;

  typedef enum logic [0:0] {st_idle, st_exec} exec_e;
  typedef enum logic [1:0] {rd_idle, rd_data, rd_done} rd_e;

endpackage

// >>> shared/regfile_if.sv
`timescale 1ns/1ps
interface regfile_if #(
  parameter int AW = 8,
  parameter int DW = 8
);
  logic [AW-1:0] addr;
  logic          we;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;

  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem  (input addr, input we, input wdata, output rdata);
endinterface

// >>> src/bit_manipulation_unit.sv
`timescale 1ns/1ps
module bit_manipulation_unit #(
  parameter int RF_AW = bit_unit_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic                              ref_clk,
  input  wire logic                              rst_b,
  // Avalon-MM slave
  input  wire logic [bit_unit_pkg::BUS_AW-1:0]   address,
  input  wire logic                              read,
  input  wire logic                              write,
  input  wire logic [bit_unit_pkg::BUS_DW/8-1:0] byteenable,
  input  wire logic [bit_unit_pkg::BUS_DW-1:0]   writedata,
  output logic      [bit_unit_pkg::BUS_DW-1:0]   readdata,
  output logic                                   waitrequest
);
  import bit_unit_pkg::*;

  if (RF_AW != ADDR_W) begin : g_chk
    $error("RF_AW must match the 8-bit register address of the operand byte");
  end

  typedef struct packed {
    exec_e       fsm;
    logic [2:0]  cyc;
    logic [23:0] instr;
    logic [7:0]  flags;
    logic [3:0]  page;
    logic        illegal;
    logic [1:0]  last_len;
    logic [7:0]  work_val;
    logic [7:0]  full_val;
    rd_e         rd;
    logic [31:0] rdata;
  } state_s;

  state_s st;
  state_s next_st;

  regfile_if #(.AW(RF_AW), .DW(DATA_W)) rf ();

  regfile_mem #(.AW(RF_AW), .DW(DATA_W)) u_mem (
    .ref_clk (ref_clk),
    .port    (rf.mem)
  );

  function automatic logic [7:0] set_bit(input logic [7:0] val, input logic [2:0] pos,
                                         input logic b);
    logic [7:0] r;
    r = val;
    r[pos] = b;
    return r;
  endfunction

  function automatic logic is_long(input logic [7:0] opc);
    return (opc == OPC_BIT_COMPARE) || (opc == OPC_BIT_OR_MERGE);
  endfunction

  function automatic logic is_known(input logic [7:0] opc);
    return (opc == OPC_BIT_COMPARE) || (opc == OPC_BIT_OR_MERGE) ||
           (opc == OPC_BIT_COMPLEMENT) || (opc == OPC_BIT_CLEAR_SET);
  endfunction

  function automatic logic [23:0] lane_merge(input logic [23:0] old, input logic [23:0] nw,
                                             input logic [2:0] be);
    logic [23:0] r;
    r = old;
    for (int i = 0; i < 3; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Instruction fields
  logic [7:0]       opc;
  logic [7:0]       byte2;
  logic [7:0]       byte3;
  logic [2:0]       bit_pos;
  logic             variant;
  logic [RF_AW-1:0] work_addr;
  logic             long_instr;
  logic [2:0]       op_step;
  logic [2:0]       last_step;
  // Bus decode, operation strobe and operation result
  logic             bus_idle;
  logic             rf_window;
  logic [RF_AW-1:0] bus_rf_addr;
  logic             start_acc;
  logic [7:0]       wr_opc;
  logic             do_op;
  logic             res_bit;
  logic [7:0]       res_val;

  assign opc         = st.instr[7:0];
  assign byte2       = st.instr[15:8];
  assign byte3       = st.instr[23:16];
  assign bit_pos     = byte2[B2_BIT_LSB +: 3];
  assign variant     = byte2[B2_VARIANT_BIT];
  assign work_addr   = {st.page, byte2[B2_REG_LSB +: 4]};
  assign long_instr  = is_long(opc);
  assign op_step     = long_instr ? STEP_OP_LONG : STEP_OP_SHORT;
  assign last_step   = (long_instr ? CYCLES_LONG : CYCLES_SHORT) - 3'h1;
  assign bus_idle    = (st.fsm == st_idle);
  assign rf_window   = (address[11:10] == OFF_RF_BASE[11:10]);
  assign bus_rf_addr = address[2 +: RF_AW];
  assign start_acc   = write && bus_idle && byteenable[0] && (address == OFF_CTRL) &&
                       writedata[CTRL_START_BIT];
  assign wr_opc      = opc;
  assign do_op       = (st.fsm == st_exec) && (st.cyc == op_step);

  // Stall everything while an instruction runs; a read takes three edges once the unit is idle
  assign waitrequest = (write && !bus_idle) || (read && (!bus_idle || st.rd != rd_done));
  assign readdata    = st.rdata;

  always_comb begin
    next_st  = st;
    rf.addr  = bus_rf_addr;
    rf.we    = 1'b0;
    rf.wdata = writedata[DATA_W-1:0];
    res_bit  = 1'b0;
    res_val  = st.work_val;

    // Register reads
    if (read && bus_idle) begin
      case (st.rd)
        rd_idle: next_st.rd = rd_data;
        rd_data: begin
          next_st.rd    = rd_done;
          next_st.rdata = '0;
          if (rf_window) begin
            next_st.rdata[DATA_W-1:0] = rf.rdata;
          end else begin
            case (address)
              OFF_INSTR: next_st.rdata[23:0] = st.instr;
              OFF_FLAGS: next_st.rdata[7:0]  = st.flags;
              OFF_PAGE:  next_st.rdata[3:0]  = st.page;
              OFF_STATUS: begin
                next_st.rdata[STAT_BUSY_BIT]       = !bus_idle;
                next_st.rdata[STAT_ILLEGAL_BIT]    = st.illegal;
                next_st.rdata[STAT_LEN_LSB +: 2]   = st.last_len;
              end
              default: next_st.rdata = '0;
            endcase
          end
        end
        default: next_st.rd = rd_idle;
      endcase
    end else begin
      next_st.rd = rd_idle;
    end

    // Register writes
    if (write && bus_idle) begin
      if (rf_window) begin
        rf.we = byteenable[0];
      end else if (address == OFF_INSTR) begin
        next_st.instr = lane_merge(st.instr, writedata[23:0], byteenable[2:0]);
      end else if (address == OFF_FLAGS && byteenable[0]) begin
        next_st.flags = writedata[7:0];
      end else if (address == OFF_PAGE && byteenable[0]) begin
        next_st.page = writedata[3:0];
      end
    end

    // Launch; an opcode outside this unit is refused and flagged
    if (start_acc) begin
      next_st.illegal = 1'b0;
      if (is_known(wr_opc)) begin
        next_st.fsm      = st_exec;
        next_st.cyc      = STEP_READ_WORK;
        next_st.last_len = is_long(wr_opc) ? BYTES_LONG : BYTES_SHORT;
      end else begin
        next_st.illegal = 1'b1;
      end
    end

    // Execution sequence: fetch working register, then full register, then act
    if (st.fsm == st_exec) begin
      next_st.cyc = st.cyc + 3'h1;
      case (st.cyc)
        STEP_READ_WORK: rf.addr = work_addr;
        STEP_READ_FULL: begin
          next_st.work_val = rf.rdata;
          rf.addr          = byte3;
        end
        STEP_OP_SHORT: next_st.full_val = rf.rdata;
        default: rf.addr = work_addr;
      endcase
      if (do_op) begin
        rf.addr = work_addr;
        case (opc)
          OPC_BIT_COMPARE: begin
            // Operands are only read, never written back
            next_st.flags[FLAG_Z] = (st.work_val[0] == st.full_val[bit_pos]);
            next_st.flags[FLAG_S] = 1'b0;
          end
          OPC_BIT_COMPLEMENT: begin
            res_val = st.work_val ^ (8'h01 << bit_pos);
            rf.we   = 1'b1;
            rf.wdata = res_val;
            next_st.flags[FLAG_Z] = (res_val == 8'h00);
            next_st.flags[FLAG_S] = 1'b0;
          end
          OPC_BIT_CLEAR_SET: begin
            res_val  = set_bit(st.work_val, bit_pos, variant);
            rf.we    = 1'b1;
            rf.wdata = res_val;
          end
          OPC_BIT_OR_MERGE: begin
            if (!variant) begin
              res_bit  = st.work_val[0] | st.full_val[bit_pos];
              rf.wdata = set_bit(st.work_val, 3'h0, res_bit);
            end else begin
              res_bit  = st.full_val[bit_pos] | st.work_val[0];
              rf.addr  = byte3;
              rf.wdata = set_bit(st.full_val, bit_pos, res_bit);
            end
            rf.we = 1'b1;
            next_st.flags[FLAG_Z] = !res_bit;
            next_st.flags[FLAG_S] = 1'b0;
          end
          default: rf.we = 1'b0;
        endcase
        // Overflow is left alone so the result is repeatable
      end
      if (st.cyc == last_step) begin
        next_st.fsm = st_idle;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st          <= '0;
      st.fsm      <= st_idle;
      st.rd       <= rd_idle;
      st.instr    <= INSTR_RST;
      st.flags    <= FLAGS_RST;
      st.page     <= PAGE_RST;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  compare_zero_a: assert property (do_op && opc == OPC_BIT_COMPARE |=>
    st.flags[FLAG_Z] == ($past(st.work_val[0]) == $past(st.full_val[bit_pos])))
    else $error("bit compare zero flag wrong");

  compare_nowrite_a: assert property (st.fsm == st_exec && opc == OPC_BIT_COMPARE |->
    !rf.we ##1 (st.fsm == st_idle || !st.flags[FLAG_S] || st.cyc <= STEP_OP_LONG))
    else $error("bit compare wrote an operand");

  short_length_a: assert property (start_acc && !is_long(wr_opc) && is_known(wr_opc) |=>
    (st.fsm == st_exec) [*4] ##1 st.fsm == st_idle)
    else $error("short instruction length wrong");

  long_length_a: assert property (start_acc && is_long(wr_opc) |=>
    (st.fsm == st_exec) [*6] ##1 st.fsm == st_idle)
    else $error("long instruction length wrong");

  complement_result_a: assert property (do_op && opc == OPC_BIT_COMPLEMENT |->
    rf.we && (rf.wdata ^ st.work_val) == (8'h01 << bit_pos)
    ##1 st.flags[FLAG_Z] == ($past(rf.wdata) == 8'h00) && !st.flags[FLAG_S])
    else $error("bit complement result or flags wrong");

  clear_set_flags_a: assert property (st.fsm == st_exec && opc == OPC_BIT_CLEAR_SET |=>
    $stable(st.flags))
    else $error("bit clear or set touched a flag");

  clear_set_value_a: assert property (do_op && opc == OPC_BIT_CLEAR_SET |->
    rf.we && rf.wdata[bit_pos] == variant && rf.addr == work_addr)
    else $error("bit clear or set value wrong");

  decode_addr_a: assert property (st.fsm == st_exec && st.cyc == STEP_READ_WORK |->
    rf.addr == {st.page, byte2[7:4]})
    else $error("working register address decode wrong");

  or_into_work_a: assert property (do_op && opc == OPC_BIT_OR_MERGE && !variant |->
    rf.wdata[0] == (st.work_val[0] | st.full_val[bit_pos]) &&
    rf.wdata[7:1] == st.work_val[7:1])
    else $error("bit OR into working bit wrong");

  or_into_full_a: assert property (do_op && opc == OPC_BIT_OR_MERGE && variant |->
    rf.addr == byte3 && (rf.wdata ^ st.full_val) == ((rf.wdata ^ st.full_val) &
    (8'h01 << bit_pos)) ##1 st.flags[FLAG_Z] == !$past(res_bit))
    else $error("bit OR into register bit wrong");

  overflow_keep_a: assert property (st.fsm == st_exec |=> $stable(st.flags[FLAG_V]))
    else $error("overflow flag changed during a bit instruction");

endmodule

// >>> src/regfile_mem.sv
`timescale 1ns/1ps
module regfile_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock
  input wire logic ref_clk,
  // Register file port
  regfile_if.mem   port
);
  logic [DW-1:0] mem [2**AW];

  // Read data is registered, so every read costs one cycle of latency
  always_ff @(posedge ref_clk) begin
    if (port.we) begin
      mem[port.addr] <= port.wdata;
    end
    port.rdata <= mem[port.addr];
  end
endmodule

// >>> testbench/bit_manipulation_unit_tb_top.sv
`timescale 1ns/1ps
module bit_manipulation_unit_tb_top;
  import bit_unit_pkg::*;

  logic              ref_clk;
  logic              rst_b;
  logic [BUS_AW-1:0] address;
  logic              read;
  logic              write;
  logic [3:0]        byteenable;
  logic [BUS_DW-1:0] writedata;
  logic [BUS_DW-1:0] readdata;
  logic              waitrequest;
  int                errors;
  int                n_checks;
  int                stalls;
  logic [31:0]       rv;

  bit_manipulation_unit i_dut (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .address     (address),
    .read        (read),
    .write       (write),
    .byteenable  (byteenable),
    .writedata   (writedata),
    .readdata    (readdata),
    .waitrequest (waitrequest)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic final_report;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Sampled at the rising edge; the strobe stays up into the next call, so no edge goes idle
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    logic w;
    stalls = 0;
    address   <= a;
    writedata <= d;
    write     <= wr;
    read      <= ~wr;
    do begin
      @(posedge ref_clk);
      w  = waitrequest;
      rv = readdata;
      if (w !== 1'b0) stalls++;
    end while (w !== 1'b0);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0);
  endtask

  function automatic logic [11:0] rfa(input logic [7:0] n);
    return OFF_RF_BASE + {2'b00, n, 2'b00};
  endfunction

  // Preset flags are 8'hfc, every named flag set, so a cleared S and a kept V both show
  function automatic logic [31:0] fz(input logic z);
    logic [7:0] f;
    f = 8'hfc;
    f[FLAG_S] = 1'b0;
    f[FLAG_Z] = z;
    return {24'h0, f};
  endfunction

  // The dummy write to an unmapped place stalls exactly while the unit is busy
  task automatic ex(input logic [23:0] ins, input int cyc, input logic [1:0] len);
    wr(OFF_FLAGS, 32'hfc);
    wr(OFF_INSTR, {8'h00, ins});
    wr(OFF_CTRL, 32'h1);
    wr(12'h020, 32'h0);
    chk(stalls, cyc);
    rd(OFF_STATUS);
    chk(rv[3:0], {len, 2'b00});
  endtask

  task automatic t_reset;
    rd(OFF_FLAGS);
    chk(rv, {24'h0, FLAGS_RST});
    rd(OFF_PAGE);
    chk(rv, {28'h0, PAGE_RST});
    rd(OFF_INSTR);
    chk(rv, {8'h0, INSTR_RST});
    rd(12'h020);
    chk(rv, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_compare;
    wr(OFF_PAGE, 32'h2);
    wr(rfa(8'h21), 32'h07);
    wr(rfa(8'h01), 32'h01);
    ex({8'h01, 8'h12, OPC_BIT_COMPARE}, 6, 2'h3);
    rd(OFF_FLAGS);
    chk(rv, fz(1'b0));
    rd(rfa(8'h21));
    chk(rv, 32'h07);
    rd(rfa(8'h01));
    chk(rv, 32'h01);
    ex({8'h01, 8'h10, OPC_BIT_COMPARE}, 6, 2'h3);
    rd(OFF_FLAGS);
    chk(rv, fz(1'b1));
    $display("test compare done");
  endtask

  task automatic t_complement;
    wr(rfa(8'h21), 32'h07);
    ex({8'h00, 8'h12, OPC_BIT_COMPLEMENT}, 4, 2'h2);
    rd(rfa(8'h21));
    chk(rv, 32'h05);
    rd(OFF_FLAGS);
    chk(rv, fz(1'b0));
    wr(rfa(8'h21), 32'h02);
    ex({8'h00, 8'h12, OPC_BIT_COMPLEMENT}, 4, 2'h2);
    rd(rfa(8'h21));
    chk(rv, 32'h00);
    rd(OFF_FLAGS);
    chk(rv, fz(1'b1));
    $display("test complement done");
  endtask

  task automatic t_clear_set;
    for (int b = 0; b < 8; b++) begin
      wr(rfa(8'h21), 32'h00);
      ex({8'h00, 4'h1, b[2:0], 1'b1, OPC_BIT_CLEAR_SET}, 4, 2'h2);
      rd(rfa(8'h21));
      chk(rv, 32'h1 << b);
      rd(OFF_FLAGS);
      chk(rv, 32'hfc);
      wr(rfa(8'h21), 32'hff);
      ex({8'h00, 4'h1, b[2:0], 1'b0, OPC_BIT_CLEAR_SET}, 4, 2'h2);
      rd(rfa(8'h21));
      chk(rv, 32'hff & ~(32'h1 << b));
      rd(OFF_FLAGS);
      chk(rv, 32'hfc);
    end
    $display("test clear and set done");
  endtask

  task automatic t_or_merge;
    logic [7:0] ops [4][4] = '{'{8'h06, 8'h12, 8'h07, 8'h03}, '{8'h06, 8'h14, 8'h06, 8'h03},
                               '{8'h07, 8'h15, 8'h07, 8'h07}, '{8'h06, 8'h15, 8'h06, 8'h03}};
    logic       zs  [4]    = '{1'b0, 1'b1, 1'b0, 1'b1};
    // Rows: work reg before, second byte, work reg after, register 01 after
    for (int i = 0; i < 4; i++) begin
      wr(rfa(8'h21), {24'h0, ops[i][0]});
      wr(rfa(8'h01), 32'h03);
      ex({8'h01, ops[i][1], OPC_BIT_OR_MERGE}, 6, 2'h3);
      rd(rfa(8'h21));
      chk(rv, {24'h0, ops[i][2]});
      rd(rfa(8'h01));
      chk(rv, {24'h0, ops[i][3]});
      rd(OFF_FLAGS);
      chk(rv, fz(zs[i]));
    end
    $display("test or merge done");
  endtask

  task automatic t_illegal;
    wr(OFF_INSTR, 32'h52);
    wr(OFF_CTRL, 32'h1);
    wr(12'h020, 32'h0);
    chk(stalls, 0);
    rd(OFF_STATUS);
    chk(rv[1:0], 2'b10);
    wr(rfa(8'h21), 32'h07);
    ex({8'h00, 8'h12, OPC_BIT_COMPLEMENT}, 4, 2'h2);
    $display("test illegal done");
  endtask

  initial begin
    rst_b      = 1'b0;
    read       = 1'b0;
    write      = 1'b0;
    address    = '0;
    writedata  = '0;
    byteenable = 4'hf;
    errors     = 0;
    n_checks   = 0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_compare();
    t_complement();
    t_clear_set();
    t_or_merge();
    t_illegal();
    final_report();
  end

  // Whole run needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    final_report();
  end
endmodule
